// >>> verilog/rtc_ts_cal.sv
`timescale 1ns/1ps
`include "rtc_ts_cal_params.svh"

module rtc_ts_cal
    import rtc_ts_cal_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CE,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic TIMESTAMP_FLAG,
    input wire logic WRITE_UNLOCKED,
    input wire cal_time_type CAL_TIME,
    input wire cal_date_type CAL_DATE,
    input wire logic [15:0] SUBSECOND_COUNT,
    input wire logic CAL_PULSE_IN,
    output logic CAL_PULSE_OUT,
    output logic IRQ
);

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    // effective mask count after window forcing
    function automatic logic [8:0] eff_mask(input calib_type c);
        logic [8:0] m;
        m = c.mask_pulse_count;
        if (c.window_eight_sec) begin
            m[1:0] = 2'b00;
        end else if (c.window_sixteen_sec) begin
            m[0] = 1'b0;
        end
        return m;
    endfunction : eff_mask

    // bit reversal of the 20-bit cycle counter for even spreading
    function automatic logic [19:0] bitrev20(input logic [19:0] v);
        logic [19:0] r;
        r = 20'h0_0000;
        for (int i = 0; i < 20; i++) begin
            r[i] = v[19 - i];
        end
        return r;
    endfunction : bitrev20

    ////////////////////////////////////////////////////////////////////////////////
    // flag synchroniser and edge detection

    logic flag_meta_reg;
    logic flag_sync_reg;
    logic flag_prev_reg;
    logic flag_rise;
    logic flag_fall;

    // flag comes from the event logic outside; two stages before use
    always_ff @(posedge CLK) begin
        if (RESET) begin
            flag_meta_reg <= 1'b0;
            flag_sync_reg <= 1'b0;
            flag_prev_reg <= 1'b0;
        end else if (CE) begin
            flag_meta_reg <= TIMESTAMP_FLAG;
            flag_sync_reg <= flag_meta_reg;
            flag_prev_reg <= flag_sync_reg;
        end
    end

    assign flag_rise = flag_sync_reg & ~flag_prev_reg;
    assign flag_fall = ~flag_sync_reg & flag_prev_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // snapshot registers

    logic [31:0] time_snap_reg;
    logic [31:0] date_snap_reg;
    logic [31:0] subsec_snap_reg;

    // RESET is the backup domain reset; system reset does not reach here
    always_ff @(posedge CLK) begin
        if (RESET) begin
            time_snap_reg <= `RST_WORD;
            date_snap_reg <= `RST_WORD;
            subsec_snap_reg <= `RST_WORD;
        end else if (CE) begin
            if (flag_rise) begin
                time_snap_reg <= {9'h000, CAL_TIME.afternoon_indicator,
                    CAL_TIME.hour_tens, CAL_TIME.hour_units, 1'b0,
                    CAL_TIME.minute_tens, CAL_TIME.minute_units, 1'b0,
                    CAL_TIME.second_tens, CAL_TIME.second_units};
                date_snap_reg <= {16'h0000, CAL_DATE.weekday,
                    CAL_DATE.month_tens, CAL_DATE.month_units, 2'b00,
                    CAL_DATE.date_tens, CAL_DATE.date_units};
                subsec_snap_reg <= {16'h0000, SUBSECOND_COUNT};
            end else if (flag_fall) begin
                time_snap_reg <= `RST_WORD;
                date_snap_reg <= `RST_WORD;
                subsec_snap_reg <= `RST_WORD;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // wishbone slave

    bus_state_type bus_state_reg;
    logic bus_req;
    logic wr_take;
    logic rd_take;
    logic [7:0] word_adr;

    assign bus_req = WB_CYC_I & WB_STB_I & (bus_state_reg == BUS_IDLE);
    assign wr_take = bus_req & WB_WE_I;
    assign rd_take = bus_req & ~WB_WE_I;
    assign word_adr = {WB_ADR_I[7:2], 2'b00};

    // one wait state: ack one cycle after the request, dropped the next
    always_ff @(posedge CLK) begin
        if (RESET) begin
            bus_state_reg <= BUS_IDLE;
            WB_ACK_O <= 1'b0;
        end else if (CE) begin
            unique case (bus_state_reg)
                BUS_IDLE: begin
                    WB_ACK_O <= bus_req;
                    if (bus_req) begin
                        bus_state_reg <= BUS_ACK;
                    end
                end
                BUS_ACK: begin
                    WB_ACK_O <= 1'b0;
                    bus_state_reg <= BUS_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // calibration and control registers

    calib_type calib_reg;
    logic [2:0] irq_mask_reg;
    logic refused_ev;

    // calibration writes need full low half-word lanes, mask writes only lane 0; locked writes set a status bit
    assign refused_ev = wr_take & (word_adr == `OFS_CALIB) & ~WRITE_UNLOCKED;

    always_ff @(posedge CLK) begin
        if (RESET) begin
            calib_reg <= '0;
            irq_mask_reg <= 3'h0;
        end else if (CE && wr_take) begin
            if (word_adr == `OFS_CALIB && WRITE_UNLOCKED
                    && WB_SEL_I[1] && WB_SEL_I[0]) begin
                calib_reg.insert_pulse_enable <= WB_DAT_I[`CAL_INSERT_BIT];
                calib_reg.window_eight_sec <= WB_DAT_I[`CAL_WIN8_BIT];
                calib_reg.window_sixteen_sec <= WB_DAT_I[`CAL_WIN16_BIT];
                calib_reg.mask_pulse_count <= WB_DAT_I[`CAL_MASK_MSB:0];
            end
            if (word_adr == `OFS_IRQ_MASK && WB_SEL_I[0]) begin
                irq_mask_reg <= WB_DAT_I[2:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // smooth calibration pulse stream

    logic [19:0] cycle_cnt_reg;
    logic [19:0] slot;
    logic [8:0] mask_eff;
    logic [10:0] slot_low;
    logic [19:0] mask_thresh;
    logic mask_hit;
    logic insert_hit;
    logic insert_pend_reg;
    logic cycle_end;

    assign mask_eff = eff_mask(calib_reg);
    // bit-reversed position spreads the masked pulses evenly
    assign slot = bitrev20(cycle_cnt_reg);
    assign mask_thresh = {11'h000, mask_eff};
    assign mask_hit = CAL_PULSE_IN & (slot < mask_thresh);
    assign slot_low = cycle_cnt_reg[10:0];
    // one insertion per 2^11 pulses gives 512 per 2^20 cycle
    assign insert_hit = CAL_PULSE_IN & calib_reg.insert_pulse_enable
        & (slot_low == 11'h7FF);
    assign cycle_end = CAL_PULSE_IN & (cycle_cnt_reg == 20'hF_FFFF);

    // counts input calendar pulses over the 2^20-pulse (32 s) cycle
    always_ff @(posedge CLK) begin
        if (RESET) begin
            cycle_cnt_reg <= 20'h0_0000;
        end else if (CE && CAL_PULSE_IN) begin
            cycle_cnt_reg <= cycle_cnt_reg + 20'h0_0001;
        end
    end

    // inserted pulse goes out in the gap after the triggering pulse;
    // limitation: input pulses must be at least two clocks apart
    always_ff @(posedge CLK) begin
        if (RESET) begin
            insert_pend_reg <= 1'b0;
            CAL_PULSE_OUT <= 1'b0;
        end else if (CE) begin
            insert_pend_reg <= insert_hit & ~mask_hit;
            CAL_PULSE_OUT <= (CAL_PULSE_IN & ~mask_hit) | insert_pend_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt status, read clears, set wins over clear

    logic [2:0] irq_stat_reg;
    logic [2:0] irq_ev;
    logic stat_rd;

    assign irq_ev = {cycle_end, refused_ev, flag_rise};
    assign stat_rd = rd_take & (word_adr == `OFS_IRQ_STATUS);

    always_ff @(posedge CLK) begin
        if (RESET) begin
            irq_stat_reg <= 3'h0;
            IRQ <= 1'b0;
        end else if (CE) begin
            irq_stat_reg <= (stat_rd ? 3'h0 : irq_stat_reg) | irq_ev;
            IRQ <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read data

    // sampled at the request edge, presented with ack
    always_ff @(posedge CLK) begin
        if (RESET) begin
            WB_DAT_O <= `RST_WORD;
        end else if (CE && rd_take) begin
            unique case (word_adr)
                `OFS_TIME_SNAP: WB_DAT_O <= time_snap_reg;
                `OFS_DATE_SNAP: WB_DAT_O <= date_snap_reg;
                `OFS_SUBSEC_SNAP: WB_DAT_O <= subsec_snap_reg;
                `OFS_CALIB: WB_DAT_O <= {16'h0000, calib_reg.insert_pulse_enable,
                    calib_reg.window_eight_sec, calib_reg.window_sixteen_sec,
                    4'h0, calib_reg.mask_pulse_count};
                `OFS_IRQ_STATUS: WB_DAT_O <= {29'h0000_0000, irq_stat_reg};
                `OFS_IRQ_MASK: WB_DAT_O <= {29'h0000_0000, irq_mask_reg};
                `OFS_CTRL_STATUS: WB_DAT_O <= {mask_eff, 3'h0, cycle_cnt_reg};
                default: WB_DAT_O <= `RST_WORD;
            endcase
        end
    end

endmodule : rtc_ts_cal

// >>> verilog/rtc_ts_cal_params.svh
`ifndef RTC_TS_CAL_PARAMS_SVH
`define RTC_TS_CAL_PARAMS_SVH

// register byte offsets
`define OFS_TIME_SNAP 8'h30
`define OFS_DATE_SNAP 8'h34
`define OFS_SUBSEC_SNAP 8'h38
`define OFS_CALIB 8'h3C
`define OFS_IRQ_STATUS 8'h44
`define OFS_IRQ_MASK 8'h48
`define OFS_CTRL_STATUS 8'h4C

// reset values
`define RST_WORD 32'h0000_0000

// calibration field positions
`define CAL_INSERT_BIT 15
`define CAL_WIN8_BIT 14
`define CAL_WIN16_BIT 13
`define CAL_MASK_MSB 8

// time snapshot fields
`define TS_AFTERNOON_BIT 22
`define TS_HOUR_LSB 16
`define TS_MIN_LSB 8

// date snapshot fields
`define DS_WEEKDAY_LSB 13
`define DS_MONTH_LSB 8

// calibration cycle figures
`define CAL_CYCLE_LOG2 20
`define CAL_INSERT_LOG2 11

// interrupt status bits
`define IRQ_SNAP_BIT 0
`define IRQ_WRITE_REFUSED_BIT 1
`define IRQ_CYCLE_END_BIT 2

`endif

// >>> verilog/rtc_ts_cal_pkg.sv
package rtc_ts_cal_pkg;

    // live calendar time as seen by the snapshot
    typedef struct packed {
        logic afternoon_indicator;
        logic [1:0] hour_tens;
        logic [3:0] hour_units;
        logic [2:0] minute_tens;
        logic [3:0] minute_units;
        logic [2:0] second_tens;
        logic [3:0] second_units;
    } cal_time_type;

    // live calendar date as seen by the snapshot
    typedef struct packed {
        logic [2:0] weekday;
        logic month_tens;
        logic [3:0] month_units;
        logic [1:0] date_tens;
        logic [3:0] date_units;
    } cal_date_type;

    // calibration control fields
    typedef struct packed {
        logic insert_pulse_enable;
        logic window_eight_sec;
        logic window_sixteen_sec;
        logic [8:0] mask_pulse_count;
    } calib_type;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_ACK
    } bus_state_type;

endpackage : rtc_ts_cal_pkg

// >>> sim/rtc_ts_cal_properties.sv
`timescale 1ns/1ps
module rtc_ts_cal_properties (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CE,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    input wire logic TIMESTAMP_FLAG,
    input wire logic CAL_PULSE_IN,
    input wire logic CAL_PULSE_OUT,
    input wire logic IRQ
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    logic [2:0] low_cnt_reg;
    logic rd_ack;
    // read answers, address still held by the master
    assign rd_ack = WB_ACK_O && !WB_WE_I;
    // flag-low age, saturating; frozen cycles do not count
    always_ff @(posedge CLK) begin
        if (RESET || TIMESTAMP_FLAG) low_cnt_reg <= 3'd0;
        else if (CE && low_cnt_reg != 3'd7) low_cnt_reg <= low_cnt_reg + 3'd1;
    end
    ////////////////////////////////////////////////////////////////////////
    property p_ack_one; (WB_ACK_O && CE) |=> !WB_ACK_O; endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
    property p_ack_due; (CE && WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O; endproperty
    a_ack_due: assert property (p_ack_due) else $error("request not answered");
    property p_ack_cause; WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_rst_quiet;
        $past(RESET) |-> !WB_ACK_O && !IRQ && !CAL_PULSE_OUT && WB_DAT_O == 32'h0000_0000;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not clear");
    property p_pulse_cause;
        (CAL_PULSE_OUT && $past(CE) && $past(CE, 2)) |-> $past(CAL_PULSE_IN) || $past(CAL_PULSE_IN, 2);
    endproperty
    a_pulse_cause: assert property (p_pulse_cause) else $error("stray pulse");
    property p_ts_clear;
        (rd_ack && WB_ADR_I[7:2] inside {6'h0C, 6'h0D, 6'h0E} && low_cnt_reg == 3'd7)
            |-> WB_DAT_O == 32'h0000_0000;
    endproperty
    a_ts_clear: assert property (p_ts_clear) else $error("snapshot not cleared");
    property p_time_rsv; (rd_ack && WB_ADR_I[7:2] == 6'h0C) |-> !(|(WB_DAT_O & 32'hFF80_8080)); endproperty
    a_time_rsv: assert property (p_time_rsv) else $error("time layout");
    property p_date_rsv; (rd_ack && WB_ADR_I[7:2] == 6'h0D) |-> !(|(WB_DAT_O & 32'hFFFF_00C0)); endproperty
    a_date_rsv: assert property (p_date_rsv) else $error("date layout");
    property p_sub_rsv; (rd_ack && WB_ADR_I[7:2] == 6'h0E) |-> WB_DAT_O[31:16] == 16'h0000; endproperty
    a_sub_rsv: assert property (p_sub_rsv) else $error("subsecond layout");
endmodule : rtc_ts_cal_properties
bind rtc_ts_cal rtc_ts_cal_properties chk_u (.CLK(CLK), .RESET(RESET), .CE(CE),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .TIMESTAMP_FLAG(TIMESTAMP_FLAG),
    .CAL_PULSE_IN(CAL_PULSE_IN), .CAL_PULSE_OUT(CAL_PULSE_OUT), .IRQ(IRQ));

// >>> sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    import rtc_ts_cal_pkg::*;
    logic clk = 0, reset = 1, ce = 1, cyc = 0, stb = 0, we = 0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = 32'h0000_0000, rdat, rd;
    logic ack, ts_flag = 0, unlocked = 1, pin = 0, pout, irq;
    cal_time_type cal_time = '0;
    cal_date_type cal_date = '0;
    logic [15:0] subsec = 16'h0000;
    int num_errors = 0, samples_checked = 0, nout = 0;

    rtc_ts_cal dut_u (.CLK(clk), .RESET(reset), .CE(ce), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .TIMESTAMP_FLAG(ts_flag), .WRITE_UNLOCKED(unlocked),
        .CAL_TIME(cal_time), .CAL_DATE(cal_date), .SUBSECOND_COUNT(subsec),
        .CAL_PULSE_IN(pin), .CAL_PULSE_OUT(pout), .IRQ(irq));

    // 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end
    // count calibrated output pulses
    always @(posedge clk) begin
        if (pout === 1'b1) nout++;
    end
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // one classic cycle; waits for ack as long as it takes, the watchdog ends a hang
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rd = rdat;
        cyc <= 0;
        stb <= 0;
    endtask : wb
    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        wb(0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask : rdchk
    // spacing of three keeps inserted pulses apart from passed ones
    task pulses(input int n);
        repeat (n) begin
            @(posedge clk);
            pin <= 1;
            @(posedge clk);
            pin <= 0;
            @(posedge clk);
        end
        repeat (4) @(posedge clk);
    endtask : pulses
    task stop_test;
        $display("errors=%0d checks=%0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        reset <= 0;
        for (int i = 0; i < 4; i++) begin
            rdchk(8'h30 + 8'(4 * i), 32'h0000_0000);
        end
        rdchk(8'h50, 32'h0000_0000);
        // full mask drops one pulse in 2048 here, counter starts at zero
        wb(1, 8'h3C, 32'h0000_01FF);
        nout = 0;
        pulses(2048);
        chk(32'(nout), 32'd2047);
        wb(1, 8'h3C, 32'h0000_8000);
        nout = 0;
        pulses(2048);
        chk(32'(nout), 32'd2049);
        rdchk(8'h4C, 32'h0000_1000);
        wb(1, 8'h3C, 32'h0000_41FF);
        rdchk(8'h4C, 32'hFE00_1000);
        wb(1, 8'h3C, 32'h0000_21FF);
        rdchk(8'h4C, 32'hFF00_1000);
        wb(1, 8'h3C, 32'h0000_9FFF);
        rdchk(8'h3C, 32'h0000_81FF);
        // locked write: ignored, flagged, raises the interrupt only if enabled
        wb(0, 8'h44, 32'h0000_0000);
        wb(1, 8'h48, 32'h0000_0002);
        unlocked <= 0;
        wb(1, 8'h3C, 32'h0000_0000);
        repeat (3) @(posedge clk);
        chk({31'b0, irq}, 32'h0000_0001);
        rdchk(8'h3C, 32'h0000_81FF);
        rdchk(8'h44, 32'h0000_0002);
        repeat (3) @(posedge clk);
        chk({31'b0, irq}, 32'h0000_0000);
        wb(1, 8'h48, 32'h0000_0000);
        wb(1, 8'h3C, 32'h0000_0000);
        repeat (3) @(posedge clk);
        chk({31'b0, irq}, 32'h0000_0000);
        wb(0, 8'h44, 32'h0000_0000);
        unlocked <= 1;
        // snapshot, then move the live values to prove they were latched
        cal_time <= {1'b1, 2'd1, 4'd2, 3'd5, 4'd9, 3'd4, 4'd7};
        cal_date <= {3'd5, 1'b1, 4'd2, 2'd3, 4'd1};
        subsec <= 16'h1234;
        ts_flag <= 1;
        repeat (6) @(posedge clk);
        cal_time <= '0;
        cal_date <= '0;
        subsec <= 16'hFFFF;
        rdchk(8'h30, 32'h0052_5947);
        rdchk(8'h34, 32'h0000_B231);
        rdchk(8'h38, 32'h0000_1234);
        ts_flag <= 0;
        repeat (6) @(posedge clk);
        for (int i = 0; i < 3; i++) begin
            rdchk(8'h30 + 8'(4 * i), 32'h0000_0000);
        end
        // frozen clock enable: input pulses neither count nor pass
        ce <= 0;
        nout = 0;
        pulses(4);
        ce <= 1;
        chk(32'(nout), 32'd0);
        rdchk(8'h4C, 32'hFF80_1000); // counter still at 4096
        reset <= 1;
        repeat (2) @(posedge clk);
        reset <= 0;
        rdchk(8'h3C, 32'h0000_0000);
        stop_test;
    end
    // hang guard, well past the expected run length
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        stop_test;
    end
endmodule : testbench
